// [core/tpim_regs.vh]
// register indices, control fields and reset values of the timer and ir modulator
`ifndef TPIM_REGS_VH
`define TPIM_REGS_VH

// byte address of a register is four times its index
`define TPIM_ADDR_W 12
`define TPIM_IDX_W 4
`define TPIM_IDX_CTRL 4'h0
`define TPIM_IDX_MPRE 4'h1
`define TPIM_IDX_MPER 4'h2
`define TPIM_IDX_CPRE 4'h3
`define TPIM_IDX_CPER 4'h4
`define TPIM_IDX_CCMP 4'h5
`define TPIM_IDX_CHCFG 4'h6
`define TPIM_IDX_CNT 4'h7
`define TPIM_IDX_CMP0 4'h8
`define TPIM_IDX_FLAG 4'hD

// control register fields
`define TPIM_CTRL_MAIN_EN 0
`define TPIM_CTRL_CAR_EN 1
`define TPIM_CTRL_IR 2
`define TPIM_CTRL_EVT 3
`define TPIM_CTRL_W 4

// channel configuration: capture enables low, falling-edge selects above
`define TPIM_CFG_CAP_LSB 0
`define TPIM_CFG_FALL_LSB 5
`define TPIM_CFG_W 10

// reset values
`define TPIM_RST_CTRL 4'h0
`define TPIM_RST_MPRE 16'h0000
`define TPIM_RST_MPER 16'hFFFF
`define TPIM_RST_CPRE 8'h00
`define TPIM_RST_CPER 8'hFF
`define TPIM_RST_CMP16 16'h0000
`define TPIM_RST_CMP8 8'h00
`define TPIM_RST_CFG 10'h000

// ahb encodings
`define TPIM_HRESP_OKAY 1'b0

`endif

// [core/tpim_top.v]
// 16-bit five-channel pwm/capture timer with 8-bit carrier timer and ir modulation
//
// How it works
// - main timer is a 16-bit counter usable as timer, event counter or pwm source.
// - main count rate comes from a programmable prescaler; range bounded by 16-bit period.
// - five independent channels, each with its own 16-bit compare value.
// - each channel is a pwm output or captures the counter on an input edge.
// - in infrared_modulation_mode main timer advances once per carrier period.
// - in infrared_modulation_mode output is main output anded with carrier output.
// - carrier timer is 8-bit with prescaler and 8-bit period value.
// - carrier timer has one channel with 8-bit compare, used as pwm output.
`timescale 1ns/1ps
`include "tpim_regs.vh"

module tpim_top #(
    parameter NUM_CH = 5,
    parameter MAIN_W = 16,
    parameter CAR_W = 8
) (
    input wire hclk,                     // system clock, 40 mhz
    input wire hresetn,                  // asynchronous reset, active low
    input wire hsel,                     // slave select
    input wire [`TPIM_ADDR_W-1:0] haddr, // byte address
    input wire [1:0] htrans,             // transfer type
    input wire hwrite,                   // write when high
    input wire [2:0] hsize,              // transfer size, word only
    input wire [31:0] hwdata,            // write data
    input wire hready,                   // bus ready
    output reg [31:0] hrdata,            // read data
    output reg hreadyout,                // slave ready
    output reg hresp,                    // always okay
    input wire [NUM_CH-1:0] cap_in,      // capture input pins
    input wire evt_in,                   // event count input pin
    output reg [NUM_CH-1:0] pwm_out,     // channel pwm outputs
    output reg car_out,                  // carrier pwm output
    output reg ir_out                    // modulated infrared output
);

    // flag whether a byte address lands on a mapped register index
    function tpim_hit;
        input [`TPIM_ADDR_W-1:0] a;
        begin
            tpim_hit = (a[`TPIM_ADDR_W-1:6] == 0) && (a[5:2] <= `TPIM_IDX_FLAG);
        end
    endfunction

    reg [`TPIM_CTRL_W-1:0] ctrl_q;
    reg [MAIN_W-1:0] mpre_q;
    reg [MAIN_W-1:0] mper_q;
    reg [CAR_W-1:0] cpre_q;
    reg [CAR_W-1:0] cper_q;
    reg [CAR_W-1:0] ccmp_q;
    reg [`TPIM_CFG_W-1:0] cfg_q;
    reg [NUM_CH-1:0] flag_q;

    reg [MAIN_W-1:0] mcnt_q;
    reg [MAIN_W-1:0] mdiv_q;
    reg [CAR_W-1:0] ccnt_q;
    reg [CAR_W-1:0] cdiv_q;

    reg wr_pend_q;
    reg [`TPIM_IDX_W-1:0] wr_idx_q;
    reg evt_s1_q;
    reg evt_s2_q;
    reg evt_s3_q;
    reg [31:0] rd_d;

    wire [NUM_CH*MAIN_W-1:0] ch_val;
    wire [NUM_CH-1:0] ch_cap_ev;
    wire [NUM_CH-1:0] ch_pwm;

    wire main_en = ctrl_q[`TPIM_CTRL_MAIN_EN];
    wire car_en = ctrl_q[`TPIM_CTRL_CAR_EN];
    wire ir_mode = ctrl_q[`TPIM_CTRL_IR];
    wire evt_mode = ctrl_q[`TPIM_CTRL_EVT];

    wire addr_phase = hsel & htrans[1] & hready;
    wire wr_any = wr_pend_q;
    wire flag_wr = wr_any & (wr_idx_q == `TPIM_IDX_FLAG);

    // ---------------- bus slave ----------------
    // zero wait states: address taken at one edge, data phase completes at the next
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= `TPIM_IDX_CTRL;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= `TPIM_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= `TPIM_HRESP_OKAY;
            wr_pend_q <= addr_phase & hwrite & tpim_hit(haddr);
            if (addr_phase) begin
                wr_idx_q <= haddr[5:2];
            end
            if (addr_phase & ~hwrite) begin
                hrdata <= rd_d;
            end
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin : rd_mux
        integer k;
        k = 0;
        rd_d = 32'h0000_0000;
        if (tpim_hit(haddr)) begin
            case (haddr[5:2])
                `TPIM_IDX_CTRL: rd_d = {{(32-`TPIM_CTRL_W){1'b0}}, ctrl_q};
                `TPIM_IDX_MPRE: rd_d = {{(32-MAIN_W){1'b0}}, mpre_q};
                `TPIM_IDX_MPER: rd_d = {{(32-MAIN_W){1'b0}}, mper_q};
                `TPIM_IDX_CPRE: rd_d = {{(32-CAR_W){1'b0}}, cpre_q};
                `TPIM_IDX_CPER: rd_d = {{(32-CAR_W){1'b0}}, cper_q};
                `TPIM_IDX_CCMP: rd_d = {{(32-CAR_W){1'b0}}, ccmp_q};
                `TPIM_IDX_CHCFG: rd_d = {{(32-`TPIM_CFG_W){1'b0}}, cfg_q};
                `TPIM_IDX_CNT: rd_d = {{(32-MAIN_W-CAR_W){1'b0}}, ccnt_q, mcnt_q};
                `TPIM_IDX_FLAG: rd_d = {{(32-NUM_CH){1'b0}}, flag_q};
                default: rd_d = 32'h0000_0000;
            endcase
            for (k = 0; k < NUM_CH; k = k + 1) begin
                if (haddr[5:2] == `TPIM_IDX_CMP0 + k) begin
                    rd_d = {{(32-MAIN_W){1'b0}}, ch_val[k*MAIN_W +: MAIN_W]};
                end
            end
        end
    end

    // ---------------- configuration registers ----------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `TPIM_RST_CTRL;
            mpre_q <= `TPIM_RST_MPRE;
            mper_q <= `TPIM_RST_MPER;
            cpre_q <= `TPIM_RST_CPRE;
            cper_q <= `TPIM_RST_CPER;
            ccmp_q <= `TPIM_RST_CMP8;
            cfg_q <= `TPIM_RST_CFG;
        end else if (wr_any) begin
            case (wr_idx_q)
                `TPIM_IDX_CTRL: ctrl_q <= hwdata[`TPIM_CTRL_W-1:0];
                `TPIM_IDX_MPRE: mpre_q <= hwdata[MAIN_W-1:0];
                `TPIM_IDX_MPER: mper_q <= hwdata[MAIN_W-1:0];
                `TPIM_IDX_CPRE: cpre_q <= hwdata[CAR_W-1:0];
                `TPIM_IDX_CPER: cper_q <= hwdata[CAR_W-1:0];
                `TPIM_IDX_CCMP: ccmp_q <= hwdata[CAR_W-1:0];
                `TPIM_IDX_CHCFG: cfg_q <= hwdata[`TPIM_CFG_W-1:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // capture flags: write one to clear, a capture in the same cycle wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= {NUM_CH{1'b0}};
        end else begin
            flag_q <= (flag_q & ~({NUM_CH{flag_wr}} & hwdata[NUM_CH-1:0])) | ch_cap_ev;
        end
    end

    // ---------------- carrier timer ----------------
    // carrier prescaler tick
    wire car_tick = car_en & (cdiv_q == cpre_q);
    // carrier period completes on the tick at which count equals period
    wire car_wrap = car_tick & (ccnt_q == cper_q);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cdiv_q <= {CAR_W{1'b0}};
            ccnt_q <= {CAR_W{1'b0}};
        end else if (!car_en) begin
            // stopping the carrier also rewinds it, so a restart begins a full period
            cdiv_q <= {CAR_W{1'b0}};
            ccnt_q <= {CAR_W{1'b0}};
        end else begin
            cdiv_q <= car_tick ? {CAR_W{1'b0}} : cdiv_q + 1'b1;
            if (car_wrap) begin
                ccnt_q <= {CAR_W{1'b0}};
            end else if (car_tick) begin
                ccnt_q <= ccnt_q + 1'b1;
            end
        end
    end

    // ---------------- main timer ----------------
    // event input crosses into the clock domain before edge detection
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_s1_q <= 1'b0;
            evt_s2_q <= 1'b0;
            evt_s3_q <= 1'b0;
        end else begin
            evt_s1_q <= evt_in;
            evt_s2_q <= evt_s1_q;
            evt_s3_q <= evt_s2_q;
        end
    end

    wire evt_rise = evt_s2_q & ~evt_s3_q;
    wire mpre_tick = (mdiv_q == mpre_q);
    // event counting or timing; carrier periods drive the count in ir mode
    wire main_tick = main_en & (ir_mode ? car_wrap : (evt_mode ? evt_rise : mpre_tick));

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdiv_q <= {MAIN_W{1'b0}};
            mcnt_q <= {MAIN_W{1'b0}};
        end else if (!main_en) begin
            mdiv_q <= {MAIN_W{1'b0}};
            mcnt_q <= {MAIN_W{1'b0}};
        end else begin
            mdiv_q <= mpre_tick ? {MAIN_W{1'b0}} : mdiv_q + 1'b1;
            // restart from zero after the period value
            if (main_tick) begin
                mcnt_q <= (mcnt_q == mper_q) ? {MAIN_W{1'b0}} : mcnt_q + 1'b1;
            end
        end
    end

    // ---------------- channels ----------------
    // one compare register and edge logic per channel
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i = i + 1) begin : gen_ch
            reg [MAIN_W-1:0] cmp_q;
            reg s1_q;
            reg s2_q;
            reg s3_q;
            wire cap_mode = cfg_q[`TPIM_CFG_CAP_LSB + i];
            wire fall_sel = cfg_q[`TPIM_CFG_FALL_LSB + i];
            wire edge_hit = fall_sel ? (s3_q & ~s2_q) : (s2_q & ~s3_q);
            wire cmp_wr = wr_any & (wr_idx_q == `TPIM_IDX_CMP0 + i);

            // capture the counter on the selected edge
            assign ch_cap_ev[i] = cap_mode & main_en & edge_hit;
            assign ch_val[i*MAIN_W +: MAIN_W] = cmp_q;
            // high below compare, low from match to period end
            assign ch_pwm[i] = ~cap_mode & main_en & (mcnt_q < cmp_q);

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    cmp_q <= `TPIM_RST_CMP16;
                end else begin
                    s1_q <= cap_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // a capture beats a software write landing in the same cycle
                    if (ch_cap_ev[i]) begin
                        cmp_q <= mcnt_q;
                    end else if (cmp_wr) begin
                        cmp_q <= hwdata[MAIN_W-1:0];
                    end
                end
            end
        end
    endgenerate

    // ---------------- outputs ----------------
    // carrier pwm from its single compare
    wire car_pwm = car_en & (ccnt_q < ccmp_q);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_out <= {NUM_CH{1'b0}};
            car_out <= 1'b0;
            ir_out <= 1'b0;
        end else begin
            pwm_out <= ch_pwm;
            car_out <= car_pwm;
            // envelope from channel 0 gates the carrier; both terms share one lag
            ir_out <= ir_mode & ch_pwm[0] & car_pwm;
        end
    end

endmodule

// [tb/tpim_top_asserts.sv]
// port checker for the timer and ir modulator
`timescale 1ns/1ps
`include "tpim_regs.vh"
module tpim_top_asserts #(parameter NUM_CH = 5) (
    input wire hclk, // clock
    input wire hresetn, // reset, low
    input wire hsel, // select
    input wire [`TPIM_ADDR_W-1:0] haddr, // address
    input wire [1:0] htrans, // transfer
    input wire hwrite, // write
    input wire [2:0] hsize, // size
    input wire [31:0] hwdata, // wdata
    input wire hready, // ready in
    input wire [31:0] hrdata, // rdata
    input wire hreadyout, // ready out
    input wire hresp, // response
    input wire [NUM_CH-1:0] cap_in, // capture pins
    input wire evt_in, // event pin
    input wire [NUM_CH-1:0] pwm_out, // pwm pins
    input wire car_out, // carrier pin
    input wire ir_out // modulated pin
);
    logic ctrl_wr_q;
    logic [3:0] ctrl_q;
    wire take = hsel && htrans[1] && hready;
    // shadow of the control word so output gating can be judged from the ports
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_wr_q <= 1'b0;
            ctrl_q <= 4'h0;
        end else begin
            ctrl_wr_q <= take && hwrite && haddr == 12'h000;
            if (ctrl_wr_q) ctrl_q <= hwdata[3:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_hole;
        take && !hwrite && (haddr[11:6] != 6'h00 || haddr[5:2] > 4'hD);
    endsequence
    sequence s_rd_ctrl;
        take && !hwrite && haddr == 12'h000;
    endsequence
    a_hole_reads_zero: assert property (s_rd_hole |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_upper_zero: assert property (s_rd_ctrl |=> hrdata[31:4] == 28'h0)
        else $error("control upper bits set");
    a_rdata_holds: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved");
    a_resp_okay: assert property (hresp == `TPIM_HRESP_OKAY)
        else $error("response not okay");
    a_zero_wait: assert property (hreadyout)
        else $error("wait state inserted");
    a_ir_gated: assert property (ir_out |-> car_out && pwm_out[0])
        else $error("modulated output outside envelope");
    a_ir_mode_off: assert property (!ctrl_q[2] [*3] |-> !ir_out)
        else $error("modulated output outside ir mode");
    a_main_off_quiet: assert property (!ctrl_q[0] [*3] |-> pwm_out == '0)
        else $error("pwm active while main timer off");
endmodule
bind tpim_top tpim_top_asserts #(.NUM_CH(NUM_CH)) u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cap_in(cap_in), .evt_in(evt_in), .pwm_out(pwm_out),
    .car_out(car_out), .ir_out(ir_out));

// [tb/tpim_pin_load.sv]
// pin load model: counts high cycles and rising edges on three outputs
`timescale 1ns/1ps
module tpim_pin_load (
    input wire hclk, // clock
    input wire clr, // clears the counts
    input wire [2:0] sig, // pwm0, carrier, modulated
    output logic [23:0] hi_cnt, // high cycles, a byte each
    output logic [23:0] rs_cnt // rising edges, a byte each
);
    logic [2:0] prev_q;
    always @(posedge hclk) begin
        prev_q <= sig;
        for (int i = 0; i < 3; i++) begin
            if (clr) begin
                hi_cnt[i*8 +: 8] <= 8'h00;
                rs_cnt[i*8 +: 8] <= 8'h00;
            end else begin
                hi_cnt[i*8 +: 8] <= hi_cnt[i*8 +: 8] + {7'h00, sig[i]};
                rs_cnt[i*8 +: 8] <= rs_cnt[i*8 +: 8] + {7'h00, sig[i] & ~prev_q[i]};
            end
        end
    end
endmodule

// [tb/tb.sv]
// self-checking bench for the timer and ir modulator
`timescale 1ns/1ps
`include "tpim_regs.vh"
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [4:0] cap_in = 5'h04;
    logic evt_in = 1'b0;
    logic clr = 1'b0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, car_out, ir_out;
    wire [4:0] pwm_out;
    wire [23:0] hi_cnt, rs_cnt;
    logic [31:0] seen, rd;
    logic [15:0] r;
    logic [31:0] expq[$];
    event got;
    int miscompares = 0;
    int cmp_count = 0;
    always #12.5 hclk = ~hclk;
    tpim_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cap_in(cap_in),
        .evt_in(evt_in), .pwm_out(pwm_out), .car_out(car_out), .ir_out(ir_out));
    tpim_pin_load i_load (.hclk(hclk), .clr(clr), .sig({ir_out, car_out, pwm_out[0]}),
        .hi_cnt(hi_cnt), .rs_cnt(rs_cnt));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [31:0] v, input logic [31:0] e);
        cmp_count++;
        if (v !== e) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, v, e);
        end
    endtask
    task automatic results();
        $display("compared %0d, wrong %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // the watcher takes the oldest expectation whenever a result is posted
    always @(got) check(seen, expq.pop_front());
    task automatic note(input logic [31:0] v, input logic [31:0] e);
        expq.push_back(e);
        seen = v;
        -> got;
        #1;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                miscompares++;
                results();
            end
            @(posedge hclk);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        note(rd, e);
    endtask
    // 40 cycles is a whole number of every output period used below
    task automatic win();
        repeat (10) @(posedge hclk);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        repeat (40) @(posedge hclk);
        #1;
    endtask
    initial begin
        r = 16'h0006;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a <= 64; a += 4) begin
            rdchk(12'(a), a == 8 ? 32'hFFFF : a == 16 ? 32'hFF : 32'h0);
        end
        $display("reset values done");
        for (int c = 1; c < 5; c++) begin
            r = lfsr(r);
            wr(12'h020 + 12'(4 * c), {r, r});
            rdchk(12'h020 + 12'(4 * c), {16'h0, r});
        end
        wr(12'h01C, 32'h1234);
        rdchk(12'h01C, 32'h0);
        $display("compare registers done");
        wr(12'h008, 32'h3);
        wr(12'h000, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(12'h004, k == 3 ? 32'h1 : 32'h0);
            wr(12'h020, k == 1 ? 32'h0 : k == 2 ? 32'h5 : 32'h2);
            win();
            note({24'h0, hi_cnt[7:0]}, k == 1 ? 32'h0 : k == 2 ? 32'h28 : 32'h14);
            note({24'h0, rs_cnt[7:0]}, k == 3 ? 32'h5 : k == 0 ? 32'hA : 32'h0);
        end
        // the random compares of channels 1 to 4 all lie above the period of 3
        note({28'h0, pwm_out[4:1]}, 32'hF);
        $display("pwm done");
        wr(12'h000, 32'h0);
        wr(12'h010, 32'h3);
        wr(12'h014, 32'h2);
        wr(12'h008, 32'h1);
        wr(12'h020, 32'h1);
        wr(12'h000, 32'h7);
        win();
        note({24'h0, hi_cnt[15:8]}, 32'h14);
        note({24'h0, rs_cnt[15:8]}, 32'hA);
        note({24'h0, hi_cnt[23:16]}, 32'hA);
        note({24'h0, rs_cnt[23:16]}, 32'h5);
        $display("ir done");
        wr(12'h000, 32'h0);
        wr(12'h008, 32'hFFFF);
        wr(12'h018, 32'h86);
        wr(12'h000, 32'h9);
        repeat (10) begin
            repeat (2) @(posedge hclk);
            evt_in <= ~evt_in;
        end
        rdchk(12'h01C, 32'h5);
        @(posedge hclk);
        cap_in <= 5'h02;
        repeat (6) @(posedge hclk);
        rdchk(12'h024, 32'h5);
        rdchk(12'h028, 32'h5);
        rdchk(12'h034, 32'h6);
        wr(12'h034, 32'h2);
        rdchk(12'h034, 32'h4);
        // capture channels stay silent, channel 0 is past its compare of 1
        note({27'h0, pwm_out}, 32'h18);
        $display("event and capture done");
        results();
    end
endmodule
